// ==== design/sro_pkg.sv ====
// Shared constants, types and register map of the status, interrupt
// and reset output block.
// Assumes a single 100 MHz clock and a 32-bit AXI4-Lite register bus.
package sro_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_FLAG = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int CTRL_W = 9;
	localparam int FLAG_LVI_BIT = 0;
	localparam int FLAG_CORE_LSB = 1;
	localparam int IRQ_DROP_BIT = 0;
	localparam int IRQ_RELEASE_BIT = 1;
	localparam int IRQ_W = 2;
	localparam int STATUS_W = 6;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

	// Status pin source codes
	localparam logic [2:0] SEL_WAKE = 3'h0;
	localparam logic [2:0] SEL_ALARM = 3'h1;
	localparam logic [2:0] SEL_UPDATE = 3'h2;
	localparam logic [2:0] SEL_EVENT = 3'h3;
	localparam logic [2:0] SEL_TEMP = 3'h4;
	localparam logic [2:0] SEL_LVI = 3'h5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint CLK_FREQ_HZ = 100_000_000;
	localparam longint RST_HOLD_MS = 60;
	localparam longint RST_HOLD_CYC = RST_HOLD_MS * (CLK_FREQ_HZ / 1000);

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Reset output sequencer states
	typedef enum logic [3:0] {
		ST_POR = 4'h1,
		ST_LOW = 4'h2,
		ST_HOLD = 4'h4,
		ST_RUN = 4'h8
	} sro_rst_state_e;

	// Internal flags from the clock core
	typedef struct packed {
		logic temp;
		logic evt;
		logic update;
		logic alarm;
		logic wake;
	} sro_flags_s;

	// Control register layout, bit 8 down to bit 0
	typedef struct packed {
		logic keep;
		logic invert;
		logic [2:0] sel;
		logic [3:0] int_en;
	} sro_cfg_s;

endpackage

// ==== design/sro_sync2.sv ====
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the reader only looks at the second stage.
module sro_sync2 import sro_pkg::*; #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// First stage, read by second stage only
	logic [W-1:0] meta_r;

	// ----------------------------------------------------------------
	// Two stage capture
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

// ==== design/sro_hold_timer.sv ====
// Counts a fixed number of cycles while its run input stays high.
// Assumes run drops to restart the count from zero.
module sro_hold_timer import sro_pkg::*; #(
	parameter int CNT_W = 23,
	parameter int HOLD = 6_000_000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	output logic done
);

	// Cycle counter
	logic [CNT_W-1:0] cnt_r;
	// Terminal count reached
	wire last = (cnt_r == CNT_W'(HOLD - 1));

	// Parameter check
	initial begin
		if (HOLD < 1 || longint'(HOLD) >= (longint'(1) << CNT_W)) begin
			$error("HOLD does not fit the counter");
		end
	end

	// ----------------------------------------------------------------
	// Count while running, done once the count is complete
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else if (!done) begin
			cnt_r <= cnt_r + CNT_W'(1);
			done <= last;
		end
	end

endmodule

// ==== design/sro_outputs.sv ====
// Output side of the clock module: interrupt pin, status pin and the
// supply supervisor reset output, with an AXI4-Lite register file.
// Assumes core flags arrive on aclk; supervisor levels are asynchronous.
// Assumes aresetn is the power-on reset of this domain.
module sro_outputs import sro_pkg::*; #(
	parameter int HOLD_CYCLES = int'(RST_HOLD_CYC),
	parameter int HOLD_W = 23
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire sro_flags_s core_flags,
	input wire logic safe_mode,
	input wire logic supply_low_async,
	input wire logic osc_stable_async,
	// Pins
	output logic int_n_out,
	output logic int_n_oe_n,
	output logic flag_status_out,
	output logic flag_status_oe_n,
	output logic rst_n_out,
	output logic rst_n_oe_n,
	output logic irq
);

	// Parameter check
	initial begin
		if (HOLD_CYCLES < 1 || HOLD_W < 2 || HOLD_W > 31) begin
			$error("Unsupported hold timer parameters");
		end
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sro_cfg_s cfg_r; // Control register
	logic lvi_flag_r; // low_voltage_init_flag
	logic [IRQ_W-1:0] irq_stat_r; // Sticky events
	logic [IRQ_W-1:0] irq_mask_r; // Event mask
	sro_rst_state_e state_r, state_nxt; // Reset sequencer
	logic [1:0] sup_s; // Synchronised supervisor levels
	logic aw_have_r, w_have_r; // Write halves captured
	logic [7:0] aw_addr_r; // Captured write address
	logic [31:0] w_data_r; // Captured write data
	logic [3:0] w_strb_r; // Captured byte enables
	logic hold_done; // Timer finished

	wire supply_low = sup_s[0]; // Supply below threshold
	wire osc_ok = sup_s[1]; // Oscillator started
	wire por_active = (state_r == ST_POR);

	// ----------------------------------------------------------------
	// Supervisor synchronisers
	// ----------------------------------------------------------------
	sro_sync2 #(.W(2)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({osc_stable_async, supply_low_async}),
		.q(sup_s)
	);

	// ----------------------------------------------------------------
	// Reset output sequencer
	// ----------------------------------------------------------------
	// hold timer runs in the hold state
	sro_hold_timer #(.CNT_W(HOLD_W), .HOLD(HOLD_CYCLES)) u_hold (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(state_r == ST_HOLD),
		.done(hold_done)
	);

	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// leave POR on good supply and oscillator
			ST_POR: begin
				if (!supply_low && osc_ok) begin
					state_nxt = ST_RUN;
				end
			end
			// Supply is down
			ST_LOW: begin
				if (!supply_low) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (supply_low) begin
					state_nxt = ST_LOW;
				end else if (hold_done) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (supply_low) begin
					state_nxt = ST_LOW;
				end
			end
			default: begin
				state_nxt = ST_POR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_POR;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Pin logic
	// ----------------------------------------------------------------
	// OR of selected interrupt sources
	wire [3:0] int_src = {core_flags.evt, core_flags.alarm, core_flags.update, core_flags.wake};
	wire int_active = |(int_src & cfg_r.int_en);
	// interrupt and status pins float in safe mode unless kept
	wire pins_off = safe_mode && !cfg_r.keep;
	// one flag chosen for the status pin
	wire [STATUS_W-1:0] status_src = {lvi_flag_r, core_flags};
	wire sel_flag = (cfg_r.sel <= SEL_LVI) ? status_src[cfg_r.sel] : 1'b0;
	wire status_lvl = sel_flag ^ cfg_r.invert;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_n_oe_n <= 1'b1;
			flag_status_out <= 1'b0;
			flag_status_oe_n <= 1'b1;
			rst_n_oe_n <= 1'b0;
		end else begin
			int_n_oe_n <= !(int_active && !pins_off);
			flag_status_out <= status_lvl;
			flag_status_oe_n <= pins_off;
			rst_n_oe_n <= (state_nxt == ST_RUN);
		end
	end

	// Open-drain pins only ever pull low
	assign int_n_out = 1'b0;
	assign rst_n_out = 1'b0;

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	wire wr_go = aw_have_r && w_have_r;
	wire wr_ok = wr_go && !por_active && w_strb_r[0];
	wire wr_mapped = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_INT_FLAG)
		|| (aw_addr_r == REG_IRQ_STAT) || (aw_addr_r == REG_IRQ_MASK)
		|| (aw_addr_r == REG_STATUS);
	wire wr_ctrl = wr_ok && (aw_addr_r == REG_CTRL);
	wire wr_flag = wr_ok && (aw_addr_r == REG_INT_FLAG);
	wire wr_stat = wr_ok && (aw_addr_r == REG_IRQ_STAT);
	wire wr_mask = wr_ok && (aw_addr_r == REG_IRQ_MASK);

	// Capture the two write halves in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else if (wr_go) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (por_active || !wr_mapped) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control and interrupt mask registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= sro_cfg_s'(CTRL_RST);
			irq_mask_r <= IRQ_MASK_RST;
		end else begin
			if (wr_ctrl) begin
				cfg_r <= sro_cfg_s'(w_data_r[CTRL_W-1:0]);
			end
			if (wr_mask) begin
				irq_mask_r <= w_data_r[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Flags and interrupt
	// ----------------------------------------------------------------
	// low-voltage flag set by POR and drops, set beats clear
	wire lvi_set = por_active || supply_low;
	wire lvi_clr = wr_flag && w_data_r[FLAG_LVI_BIT];
	wire [IRQ_W-1:0] ev_set = {state_r == ST_HOLD && state_nxt == ST_RUN,
		state_r == ST_RUN && state_nxt == ST_LOW};
	wire [IRQ_W-1:0] ev_clr = wr_stat ? w_data_r[IRQ_W-1:0] : '0;

	// Sticky bits, write one to clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvi_flag_r <= 1'b1;
			irq_stat_r <= '0;
		end else begin
			lvi_flag_r <= lvi_set || (lvi_flag_r && !lvi_clr);
			irq_stat_r <= ev_set | (irq_stat_r & ~ev_clr);
		end
	end

	// Level interrupt
	assign irq = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	wire [7:0] ra = s_axi_araddr[7:0];
	wire [31:0] st_word = {27'h000_0000, por_active, supply_low,
		!rst_n_oe_n, flag_status_out, !int_n_oe_n};
	wire [31:0] rd_word =
		(ra == REG_CTRL) ? {23'h00_0000, cfg_r} :
		(ra == REG_STATUS) ? st_word :
		(ra == REG_INT_FLAG) ? {26'h000_0000, core_flags, lvi_flag_r} :
		(ra == REG_IRQ_STAT) ? {30'h0000_0000, irq_stat_r} :
		(ra == REG_IRQ_MASK) ? {30'h0000_0000, irq_mask_r} : 32'h0000_0000;
	wire rd_mapped = (ra == REG_CTRL) || (ra == REG_STATUS) || (ra == REG_INT_FLAG)
		|| (ra == REG_IRQ_STAT) || (ra == REG_IRQ_MASK);

	// Read data registered one cycle after address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= por_active ? 32'h0000_0000 : rd_word;
			s_axi_rresp <= (por_active || !rd_mapped) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_INT_OR: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> int_n_oe_n == !($past(int_active) && !$past(pins_off)))
		else $error("Interrupt pin does not follow selected sources");

	AST_SAFE_HIZ: assert property (@(posedge aclk) disable iff (!aresetn)
		(safe_mode && !cfg_r.keep) |=> (int_n_oe_n && flag_status_oe_n))
		else $error("Pins driven in safe mode without keep");

	AST_STATUS_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_r.sel == SEL_ALARM && !cfg_r.invert) ##1 $stable(cfg_r)
		|-> flag_status_out == $past(core_flags.alarm))
		else $error("Status pin not showing selected flag");

	AST_STATUS_INV: assert property (@(posedge aclk) disable iff (!aresetn)
		(cfg_r.invert && $stable(cfg_r) && $stable(status_src))
		|=> flag_status_out == !$past(sel_flag))
		else $error("Status pin polarity wrong");

	AST_RST_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
		supply_low |=> !rst_n_oe_n)
		else $error("Reset not asserted on supply drop");

	AST_RST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == ST_LOW && !supply_low) |=> !rst_n_oe_n [*8])
		else $error("Reset released too early after recovery");

	AST_RST_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(rst_n_oe_n) |-> $past(hold_done) || $past(por_active))
		else $error("Reset released without hold time");

	AST_POR_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		por_active |-> !rst_n_oe_n ##1 lvi_flag_r)
		else $error("POR without low-voltage flag or reset");

	AST_POR_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready && por_active) |=> s_axi_rresp == RESP_SLVERR)
		else $error("Host read accepted during POR");

	AST_POR_EXIT: assert property (@(posedge aclk) disable iff (!aresetn)
		(por_active && !supply_low && osc_ok) |=> (!por_active ##0 rst_n_oe_n))
		else $error("POR not left with good supply and oscillator");

	AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		irq_stat_r[IRQ_DROP_BIT] && irq_mask_r[IRQ_DROP_BIT] |-> irq)
		else $error("Unmasked event without interrupt");

	COV_DROP_RELEASE: cover property (@(posedge aclk) disable iff (!aresetn)
		state_r == ST_HOLD ##1 state_r == ST_RUN);
	COV_INT_DRIVE: cover property (@(posedge aclk) disable iff (!aresetn)
		!int_n_oe_n);
	COV_SAFE_KEEP: cover property (@(posedge aclk) disable iff (!aresetn)
		safe_mode && cfg_r.keep && !flag_status_oe_n);

endmodule

// ==== verification/sro_pin_partner.sv ====
// Pin-side model: pull-ups on the open-drain lines, receiver on the status line.
// Assumes the bench reads the lines after the rising edge that moved them.
module sro_pin_partner (
	input wire logic aclk,
	input wire logic int_n_out,
	input wire logic int_n_oe_n,
	input wire logic flag_status_out,
	input wire logic flag_status_oe_n,
	input wire logic rst_n_out,
	input wire logic rst_n_oe_n,
	output logic int_line,
	output logic status_line,
	output logic rst_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_r; // Last level driven on the status line
	// Released open-drain lines rise to the pull-up level
	assign int_line = int_n_oe_n ? 1'b1 : int_n_out;
	assign rst_line = rst_n_oe_n ? 1'b1 : rst_n_out;
	// Floating status line shows the inverse of its last level
	assign status_line = flag_status_oe_n ? !last_r : flag_status_out;
	// Remember what was driven
	always_ff @(posedge aclk) begin
		if (!flag_status_oe_n) begin
			last_r <= flag_status_out;
		end
	end
endmodule

// ==== verification/tb_sro_outputs.sv ====
// Bench for the output block: register traffic, pin levels, reset link.
// Assumes the pin model resolves the open-drain lines with pull-ups.
module tb_sro_outputs import sro_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20; // Shortened 60 ms hold
	logic aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_rdy, ar_v, ar_r, r_v, r_rdy;
	logic [31:0] aw_addr, w_data, ar_addr, r_data, seed;
	logic [3:0] w_strb;
	logic [1:0] b_resp, r_resp;
	sro_flags_s flags; // Core flag levels
	sro_cfg_s cfg; // Control value written
	logic safe, sup_low, osc_ok, int_o, int_oe_n, st_o, st_oe_n, rst_o, rst_oe_n, irq;
	logic int_line, st_line, rst_line;
	int error_cnt, num_checks, cyc, n;
	sro_outputs #(.HOLD_CYCLES(HOLD)) i_sro_outputs (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
		.s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
		.s_axi_araddr(ar_addr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
		.core_flags(flags), .safe_mode(safe), .supply_low_async(sup_low),
		.osc_stable_async(osc_ok), .int_n_out(int_o), .int_n_oe_n(int_oe_n),
		.flag_status_out(st_o), .flag_status_oe_n(st_oe_n), .rst_n_out(rst_o),
		.rst_n_oe_n(rst_oe_n), .irq(irq));
	sro_pin_partner i_sro_pin_partner (.aclk(aclk), .int_n_out(int_o),
		.int_n_oe_n(int_oe_n), .flag_status_out(st_o), .flag_status_oe_n(st_oe_n),
		.rst_n_out(rst_o), .rst_n_oe_n(rst_oe_n), .int_line(int_line),
		.status_line(st_line), .rst_line(rst_line));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected interrupt line: OR of enabled sources, floats in safe mode unless kept
	function automatic logic exp_int(sro_flags_s f, sro_cfg_s c, logic s);
		logic [3:0] src;
		src = {f.evt, f.alarm, f.update, f.wake};
		return !(|(src & c.int_en) && !(s && !c.keep));
	endfunction
	// Expected status level: selected flag, low-voltage flag cleared
	function automatic logic exp_st(sro_flags_s f, sro_cfg_s c);
		logic [7:0] v;
		v = {3'h0, f.temp, f.evt, f.update, f.alarm, f.wake};
		return v[c.sel] ^ c.invert;
	endfunction
	task automatic chk32(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic chk1(input logic e, input logic g);
		chk32({31'h0, e}, {31'h0, g});
	endtask
	task automatic chk2(input logic [1:0] e, input logic [1:0] g);
		chk32({30'h0, e}, {30'h0, g});
	endtask
	// AXI4-Lite write, both halves offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		aw_addr <= {24'h0, a};
		w_data <= d;
		aw_v <= 1;
		w_v <= 1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && aw_r) begin
				aw = 1;
				aw_v <= 0;
			end
			if (!w && w_r) begin
				w = 1;
				w_v <= 0;
			end
		end
		do @(posedge aclk); while (b_v !== 1'b1);
		chk2(er, b_resp);
	endtask
	// AXI4-Lite read, masked data compare
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input logic [1:0] er);
		ar_addr <= {24'h0, a};
		ar_v <= 1;
		do @(posedge aclk); while (ar_r !== 1'b1);
		ar_v <= 0;
		do @(posedge aclk); while (r_v !== 1'b1);
		chk2(er, r_resp);
		chk32(e, r_data & m);
	endtask
	// Cycles until the reset line reaches a level
	task automatic wait_rst(input logic lvl);
		n = 0;
		while (rst_line !== lvl && n < 400) begin
			@(posedge aclk);
			n++;
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		aclk = 0;
		forever #5 aclk = !aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{aresetn, aw_v, w_v, ar_v, safe, sup_low, osc_ok} = '0;
		{aw_addr, w_data, ar_addr} = '0;
		{error_cnt, num_checks, cyc} = '0;
		b_rdy = 1; // Responses always accepted
		r_rdy = 1;
		w_strb = 4'hf;
		flags = '0;
		seed = 32'h0001_6984;
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		// Power-on state: host refused, reset held until oscillator ready
		repeat (20) @(posedge aclk);
		chk1(1'b0, rst_line);
		chk1(1'b1, int_line);
		chk1(1'b0, st_oe_n);
		wr(REG_CTRL, 32'h0000_01ff, RESP_SLVERR);
		rd(REG_INT_FLAG, 32'hffff_ffff, 32'h0, RESP_SLVERR);
		osc_ok <= 1;
		wait_rst(1'b1);
		chk1(1'b1, n < 10);
		rd(REG_CTRL, 32'hffff_ffff, 32'h0, RESP_OKAY);
		rd(REG_INT_FLAG, 32'h1, 32'h1, RESP_OKAY);
		wr(REG_INT_FLAG, 32'h1, RESP_OKAY);
		rd(REG_INT_FLAG, 32'h1, 32'h0, RESP_OKAY);
		// Unmapped places and a write without the low byte lane
		rd(8'h14, 32'hffff_ffff, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h5, RESP_SLVERR);
		w_strb <= 4'he;
		wr(REG_CTRL, 32'h0000_01ff, RESP_OKAY);
		w_strb <= 4'hf;
		rd(REG_CTRL, 32'hffff_ffff, 32'h0, RESP_OKAY);
		// Pins: every select and polarity first, then random mixes
		for (int i = 0; i < 80; i++) begin
			cfg = (i < 16) ? sro_cfg_s'({1'b0, i[0], i[3:1], 4'hf}) : sro_cfg_s'(9'(rnd()));
			wr(REG_CTRL, {23'h0, cfg}, RESP_OKAY);
			flags <= sro_flags_s'(5'(rnd()));
			safe <= (i < 16) ? 1'b0 : 1'(rnd());
			@(posedge aclk);
			@(posedge aclk);
			chk1(exp_int(flags, cfg, safe), int_line);
			chk1(safe && !cfg.keep, st_oe_n);
			if (!(safe && !cfg.keep)) begin
				chk1(exp_st(flags, cfg), st_line);
			end
			// Core flag readback in iteration 20, among the random mixes
			if (i == 20) begin
				rd(REG_INT_FLAG, 32'h0000_003e, {26'h000_0000, flags, 1'b0}, RESP_OKAY);
			end
		end
		// Supply drop, recovery with a second drop inside the hold
		safe <= 0;
		wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
		sup_low <= 1;
		wait_rst(1'b0);
		chk1(1'b1, n < 8);
		rd(REG_IRQ_STAT, 32'h1, 32'h1, RESP_OKAY);
		chk1(1'b1, irq);
		rd(REG_INT_FLAG, 32'h1, 32'h1, RESP_OKAY);
		rd(REG_STATUS, 32'h0000_001c, 32'h0000_000c, RESP_OKAY);
		sup_low <= 0;
		repeat (10) @(posedge aclk);
		sup_low <= 1;
		repeat (4) @(posedge aclk);
		chk1(1'b0, rst_line);
		sup_low <= 0;
		wait_rst(1'b1);
		chk1(1'b1, n >= HOLD && n <= HOLD + 8);
		rd(REG_IRQ_STAT, 32'h2, 32'h2, RESP_OKAY);
		wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
		chk1(1'b0, irq);
		wr(REG_IRQ_STAT, 32'h3, RESP_OKAY);
		rd(REG_IRQ_STAT, 32'h3, 32'h0, RESP_OKAY);
		// Second reset in mid-run
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		chk1(1'b0, rst_line);
		chk1(1'b1, int_line);
		chk1(1'b1, st_oe_n);
		complete_run();
	end
endmodule
